/* verilog/aloc_pkg.sv */
package aloc_pkg;

  typedef enum logic [3:0] {
    OP_NONE, OP_SMUL, OP_UDIV, OP_SDIV, OP_ADJ_MUL, OP_ADJ_DIV,
    OP_SXB, OP_SXW, OP_AND, OP_TEST, OP_OR
  } aloc_op_e;

  typedef logic [6:0] aloc_cyc_t;

  typedef struct packed {
    aloc_op_e op;
    logic word;
    logic dir;
    logic mem;
    logic imm;
    logic acc;
    logic [2:0] reg_f;
    logic [2:0] rm;
    aloc_cyc_t cyc_min;
    aloc_cyc_t cyc_max;
  } aloc_dec_s;

  // opcode patterns: upper bits without w (6-bit AND/OR forms also without d), or whole bytes
  localparam logic [6:0] GRP3_OP = 7'h7b;
  localparam logic [6:0] TEST_RM_OP = 7'h42;
  localparam logic [6:0] TEST_ACC_OP = 7'h54;
  localparam logic [6:0] OR_ACC_OP = 7'h06;
  localparam logic [6:0] AND_ACC_OP = 7'h12;
  localparam logic [6:0] LOGIC_IMM_OP = 7'h40;
  localparam logic [5:0] AND_RM_OP = 6'h08;
  localparam logic [5:0] OR_RM_OP = 6'h02;
  localparam logic [7:0] ADJ_MUL_OP = 8'hd4;
  localparam logic [7:0] ADJ_DIV_OP = 8'hd5;
  localparam logic [7:0] ADJ_BASE = 8'h0a;
  localparam logic [7:0] SXB_OP = 8'h98;
  localparam logic [7:0] SXW_OP = 8'h99;

  localparam logic [2:0] SUB_TEST = 3'h0;
  localparam logic [2:0] SUB_OR = 3'h1;
  localparam logic [2:0] SUB_AND = 3'h4;
  localparam logic [2:0] SUB_SMUL = 3'h5;
  localparam logic [2:0] SUB_UDIV = 3'h6;
  localparam logic [2:0] SUB_SDIV = 3'h7;
  localparam logic [1:0] MOD_REG = 2'h3;

  // clock counts
  localparam aloc_cyc_t SMUL_RB_MIN = 7'h19;
  localparam aloc_cyc_t SMUL_RB_MAX = 7'h1c;
  localparam aloc_cyc_t SMUL_RW_MIN = 7'h22;
  localparam aloc_cyc_t SMUL_RW_MAX = 7'h25;
  localparam aloc_cyc_t SMUL_MB_MIN = 7'h1f;
  localparam aloc_cyc_t SMUL_MB_MIN8 = 7'h20;
  localparam aloc_cyc_t SMUL_MB_MAX = 7'h22;
  localparam aloc_cyc_t SMUL_MW_MIN = 7'h28;
  localparam aloc_cyc_t SMUL_MW_MAX = 7'h2b;
  localparam aloc_cyc_t UDIV_RB = 7'h1d;
  localparam aloc_cyc_t UDIV_RW = 7'h26;
  localparam aloc_cyc_t UDIV_MB = 7'h23;
  localparam aloc_cyc_t UDIV_MW = 7'h2c;
  localparam aloc_cyc_t SDIV_RB_MIN = 7'h2c;
  localparam aloc_cyc_t SDIV_RB_MAX = 7'h34;
  localparam aloc_cyc_t SDIV_RW_MIN = 7'h35;
  localparam aloc_cyc_t SDIV_RW_MAX = 7'h3d;
  localparam aloc_cyc_t SDIV_MB_MIN = 7'h32;
  localparam aloc_cyc_t SDIV_MB_MAX = 7'h3a;
  localparam aloc_cyc_t SDIV_MW_MIN = 7'h3b;
  localparam aloc_cyc_t SDIV_MW_MAX = 7'h43;
  localparam aloc_cyc_t ADJ_MUL_CYC = 7'h13;
  localparam aloc_cyc_t ADJ_DIV_CYC = 7'h0f;
  localparam aloc_cyc_t SXB_CYC = 7'h02;
  localparam aloc_cyc_t SXW_CYC = 7'h04;
  localparam aloc_cyc_t LOGIC_REG_CYC = 7'h03;
  localparam aloc_cyc_t LOGIC_MEM_CYC = 7'h0a;
  localparam aloc_cyc_t ACC_BYTE_CYC = 7'h03;
  localparam aloc_cyc_t ACC_WORD_CYC = 7'h04;
  localparam aloc_cyc_t IMM_REG_CYC = 7'h04;
  localparam aloc_cyc_t IMM_MEM_CYC = 7'h10;
  localparam aloc_cyc_t TEST_IMM_MEM_CYC = 7'h0a;
  localparam aloc_cyc_t BUS8_WORD_MEM_EXTRA = 7'h04;

  function automatic aloc_dec_s aloc_cycles(input aloc_dec_s d, input logic bus8);
    aloc_dec_s r;
    r = d;
    r.cyc_min = '0;
    r.cyc_max = '0;
    case (d.op)
      OP_SMUL:
      begin
        r.cyc_min = d.word ? (d.mem ? SMUL_MW_MIN : SMUL_RW_MIN)
                           : (d.mem ? (bus8 ? SMUL_MB_MIN8 : SMUL_MB_MIN) : SMUL_RB_MIN);
        r.cyc_max = d.word ? (d.mem ? SMUL_MW_MAX : SMUL_RW_MAX)
                           : (d.mem ? SMUL_MB_MAX : SMUL_RB_MAX);
      end
      OP_UDIV:
      begin
        r.cyc_min = d.word ? (d.mem ? UDIV_MW : UDIV_RW) : (d.mem ? UDIV_MB : UDIV_RB);
        r.cyc_max = r.cyc_min;
      end
      OP_SDIV:
      begin
        r.cyc_min = d.word ? (d.mem ? SDIV_MW_MIN : SDIV_RW_MIN)
                           : (d.mem ? SDIV_MB_MIN : SDIV_RB_MIN);
        r.cyc_max = d.word ? (d.mem ? SDIV_MW_MAX : SDIV_RW_MAX)
                           : (d.mem ? SDIV_MB_MAX : SDIV_RB_MAX);
      end
      OP_ADJ_MUL: r.cyc_min = ADJ_MUL_CYC;
      OP_ADJ_DIV: r.cyc_min = ADJ_DIV_CYC;
      OP_SXB: r.cyc_min = SXB_CYC;
      OP_SXW: r.cyc_min = SXW_CYC;
      OP_AND, OP_TEST, OP_OR:
      begin
        if (d.acc)
          r.cyc_min = d.word ? ACC_WORD_CYC : ACC_BYTE_CYC;
        else if (d.imm)
          r.cyc_min = d.mem ? ((d.op == OP_TEST) ? TEST_IMM_MEM_CYC : IMM_MEM_CYC)
                            : IMM_REG_CYC;
        else
          r.cyc_min = d.mem ? LOGIC_MEM_CYC : LOGIC_REG_CYC;
      end
      default: r.cyc_min = '0;
    endcase
    if (d.op != OP_SMUL && d.op != OP_SDIV)
      r.cyc_max = r.cyc_min;
    // word access to memory costs more on the narrow bus
    if (bus8 && d.word && d.mem)
    begin
      r.cyc_min = aloc_cyc_t'(r.cyc_min + BUS8_WORD_MEM_EXTRA);
      r.cyc_max = aloc_cyc_t'(r.cyc_max + BUS8_WORD_MEM_EXTRA);
    end
    return r;
  endfunction : aloc_cycles

endpackage : aloc_pkg

/* verilog/aloc_cycle_timer.sv */
`timescale 1ns/1ps
module aloc_cycle_timer (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic load_i,
  input wire aloc_pkg::aloc_cyc_t count_i,
  output logic busy_o,
  output logic done_o
);

  typedef struct packed {
    aloc_pkg::aloc_cyc_t cnt;
  } aloc_tmr_s;

  aloc_tmr_s tmr_q;
  aloc_tmr_s tmr_d;

  always_comb
  begin
    tmr_d = tmr_q;
    if (load_i)
      tmr_d.cnt = count_i;
    else if (tmr_q.cnt != '0)
      tmr_d.cnt = tmr_q.cnt - 7'h01;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      tmr_q <= '0;
    else
      tmr_q <= tmr_d;
  end

  assign busy_o = (tmr_q.cnt != '0);
  assign done_o = (tmr_q.cnt == 7'h01);

endmodule : aloc_cycle_timer

/* verilog/aloc_decode.sv */
// Contract
// - Opcode 1111011w with sub-field 101 is signed multiply, 25-28 clocks byte reg, 34-37 word reg.
// - Opcode 1111011w with sub-field 110 is unsigned divide, 44 clocks for a memory word.
// - Opcode 1111011w with sub-field 111 is signed divide, 44-52 byte reg, 53-61 word reg.
// - Bytes 11010100 then 00001010 are the decimal adjust after multiply, 19 clocks.
// - Bytes 11010101 then 00001010 are the decimal adjust before divide, 15 clocks.
// - Byte 10011000 sign-extends the low accumulator byte to 16 bits in 2 clocks.
// - Byte 10011001 sign-extends the accumulator to a 32-bit pair in 4 clocks.
// - Opcode 001000dw with a mode byte is a register/memory AND, 3 clocks reg, 10 with memory.
// - Flag-only AND decodes from 1000010w with register operand and 1010100w against accumulator.
// - Opcode 000010dw with a mode byte is a register/memory OR; 0000110w ORs data into accumulator.
// - Word operations touching memory take 4 more clocks on the 8-bit bus variant.
`timescale 1ns/1ps
module aloc_decode (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic bus8_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  output logic byte_ready_o,
  output aloc_pkg::aloc_dec_s dec_o,
  output logic busy_o,
  output logic done_o,
  output logic illegal_o
);

  typedef enum {S_IDLE, S_MODRM, S_ADJ} aloc_st_e;

  typedef struct packed {
    aloc_st_e st;
    logic [7:0] opc;
    aloc_pkg::aloc_dec_s dec;
    logic illegal;
  } aloc_state_s;

  aloc_state_s q;
  aloc_state_s d;
  aloc_pkg::aloc_dec_s nd;
  logic take;
  logic load;
  logic legal;
  logic mod_mem;
  logic [2:0] sub;

  assign take = byte_valid_i && byte_ready_o;
  assign byte_ready_o = !busy_o;
  assign mod_mem = (byte_i[7:6] != aloc_pkg::MOD_REG);
  assign sub = byte_i[5:3];

  always_comb
  begin
    d = q;
    d.illegal = 1'b0;
    nd = '0;
    legal = 1'b0;
    load = 1'b0;
    case (q.st)
      S_IDLE:
      begin
        if (take)
        begin
          nd.word = byte_i[0];
          if (byte_i == aloc_pkg::SXB_OP)
          begin
            nd.op = aloc_pkg::OP_SXB;
            nd.word = 1'b0;
            legal = 1'b1;
          end
          else if (byte_i == aloc_pkg::SXW_OP)
          begin
            nd.op = aloc_pkg::OP_SXW;
            nd.word = 1'b1;
            legal = 1'b1;
          end
          else if (byte_i[7:1] == aloc_pkg::TEST_ACC_OP)
          begin
            nd.op = aloc_pkg::OP_TEST;
            {nd.imm, nd.acc, legal} = 3'h7;
          end
          else if (byte_i[7:1] == aloc_pkg::OR_ACC_OP)
          begin
            nd.op = aloc_pkg::OP_OR;
            {nd.imm, nd.acc, legal} = 3'h7;
          end
          else if (byte_i[7:1] == aloc_pkg::AND_ACC_OP)
          begin
            nd.op = aloc_pkg::OP_AND;
            {nd.imm, nd.acc, legal} = 3'h7;
          end
          else if (byte_i == aloc_pkg::ADJ_MUL_OP || byte_i == aloc_pkg::ADJ_DIV_OP)
            d.st = S_ADJ;
          else if (byte_i[7:1] == aloc_pkg::GRP3_OP || byte_i[7:1] == aloc_pkg::TEST_RM_OP
                   || byte_i[7:1] == aloc_pkg::LOGIC_IMM_OP
                   || byte_i[7:2] == aloc_pkg::AND_RM_OP || byte_i[7:2] == aloc_pkg::OR_RM_OP)
            d.st = S_MODRM;
          else
            d.illegal = 1'b1;
          d.opc = byte_i;
        end
      end
      S_MODRM:
      begin
        if (take)
        begin
          nd.word = q.opc[0];
          nd.mem = mod_mem;
          nd.reg_f = sub;
          nd.rm = byte_i[2:0];
          legal = 1'b1;
          if (q.opc[7:1] == aloc_pkg::GRP3_OP)
          begin
            case (sub)
              aloc_pkg::SUB_SMUL: nd.op = aloc_pkg::OP_SMUL;
              aloc_pkg::SUB_UDIV: nd.op = aloc_pkg::OP_UDIV;
              aloc_pkg::SUB_SDIV: nd.op = aloc_pkg::OP_SDIV;
              aloc_pkg::SUB_TEST:
              begin
                nd.op = aloc_pkg::OP_TEST;
                nd.imm = 1'b1;
              end
              default: legal = 1'b0;
            endcase
          end
          else if (q.opc[7:1] == aloc_pkg::LOGIC_IMM_OP)
          begin
            nd.imm = 1'b1;
            case (sub)
              aloc_pkg::SUB_AND: nd.op = aloc_pkg::OP_AND;
              aloc_pkg::SUB_OR: nd.op = aloc_pkg::OP_OR;
              default: legal = 1'b0;
            endcase
          end
          else if (q.opc[7:1] == aloc_pkg::TEST_RM_OP)
            nd.op = aloc_pkg::OP_TEST;
          else
          begin
            nd.op = (q.opc[7:2] == aloc_pkg::AND_RM_OP) ? aloc_pkg::OP_AND : aloc_pkg::OP_OR;
            nd.dir = q.opc[1];
          end
          d.illegal = !legal;
          d.st = S_IDLE;
        end
      end
      S_ADJ:
      begin
        if (take)
        begin
          // second byte must be the base
          legal = (byte_i == aloc_pkg::ADJ_BASE);
          nd.op = (q.opc == aloc_pkg::ADJ_MUL_OP) ? aloc_pkg::OP_ADJ_MUL
                                                  : aloc_pkg::OP_ADJ_DIV;
          d.illegal = !legal;
          d.st = S_IDLE;
        end
      end
      default: d.st = S_IDLE;
    endcase
    if (legal)
    begin
      // cycle lookup with narrow bus penalty
      d.dec = aloc_pkg::aloc_cycles(nd, bus8_i);
      load = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      q.st <= S_IDLE;
      q.opc <= '0;
      q.dec <= '0;
      q.illegal <= 1'b0;
    end
    else
      q <= d;
  end

  aloc_cycle_timer u_timer (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .load_i(load),
    .count_i(d.dec.cyc_min),
    .busy_o(busy_o),
    .done_o(done_o)
  );

  assign dec_o = q.dec;
  assign illegal_o = q.illegal;

  AST_SMUL_BYTE: assert property (@(posedge core_clk_i) disable iff (srst_i)
    take && q.st == S_MODRM && q.opc == 8'hf6 && sub == 3'h5 && !mod_mem
    |=> dec_o.op == aloc_pkg::OP_SMUL && dec_o.cyc_min == 7'h19 && dec_o.cyc_max == 7'h1c)
    else $error("signed multiply byte register count wrong");

  AST_SMUL_WORD: assert property (@(posedge core_clk_i) disable iff (srst_i)
    take && q.st == S_MODRM && q.opc == 8'hf7 && sub == 3'h5 && !mod_mem
    |=> dec_o.cyc_min == 7'h22 && dec_o.cyc_max == 7'h25)
    else $error("signed multiply word register count wrong");

  AST_UDIV_MEMW: assert property (@(posedge core_clk_i) disable iff (srst_i)
    take && q.st == S_MODRM && q.opc == 8'hf7 && sub == 3'h6 && mod_mem && !bus8_i
    |=> dec_o.op == aloc_pkg::OP_UDIV && dec_o.cyc_min == 7'h2c && busy_o)
    else $error("unsigned divide memory word count wrong");

  AST_SDIV_REG: assert property (@(posedge core_clk_i) disable iff (srst_i)
    take && q.st == S_MODRM && q.opc[7:1] == 7'h7b && sub == 3'h7 && !mod_mem
    |=> dec_o.op == aloc_pkg::OP_SDIV
        && dec_o.cyc_max == (dec_o.word ? 7'h3d : 7'h34))
    else $error("signed divide register count wrong");

  AST_ADJ_MUL: assert property (@(posedge core_clk_i) disable iff (srst_i)
    take && q.st == S_ADJ && q.opc == 8'hd4 && byte_i == 8'h0a
    |=> dec_o.op == aloc_pkg::OP_ADJ_MUL && !done_o ##18 done_o)
    else $error("adjust after multiply not 19 clocks");

  AST_ADJ_DIV: assert property (@(posedge core_clk_i) disable iff (srst_i)
    take && q.st == S_ADJ && q.opc == 8'hd5 && byte_i == 8'h0a
    |=> busy_o && !done_o ##14 done_o ##1 !busy_o)
    else $error("adjust before divide not 15 clocks");

  AST_SXB: assert property (@(posedge core_clk_i) disable iff (srst_i)
    take && q.st == S_IDLE && byte_i == 8'h98
    |=> dec_o.op == aloc_pkg::OP_SXB && !done_o ##1 done_o ##1 byte_ready_o)
    else $error("byte sign extend not 2 clocks");

  AST_SXW: assert property (@(posedge core_clk_i) disable iff (srst_i)
    take && q.st == S_IDLE && byte_i == 8'h99
    |=> !done_o [*3] ##1 done_o)
    else $error("word sign extend not 4 clocks");

  AST_AND_RM: assert property (@(posedge core_clk_i) disable iff (srst_i)
    take && q.st == S_MODRM && q.opc[7:2] == 6'h08 && !(bus8_i && q.opc[0] && mod_mem)
    |=> dec_o.op == aloc_pkg::OP_AND && dec_o.cyc_min == (dec_o.mem ? 7'h0a : 7'h03))
    else $error("and register memory count wrong");

  AST_TEST_DEC: assert property (@(posedge core_clk_i) disable iff (srst_i)
    take && ((q.st == S_MODRM && q.opc[7:1] == 7'h42)
             || (q.st == S_IDLE && byte_i[7:1] == 7'h54))
    |=> dec_o.op == aloc_pkg::OP_TEST && !illegal_o)
    else $error("flag-only and not decoded");

  AST_OR_DEC: assert property (@(posedge core_clk_i) disable iff (srst_i)
    take && ((q.st == S_MODRM && q.opc[7:2] == 6'h02)
             || (q.st == S_IDLE && byte_i[7:1] == 7'h06))
    |=> dec_o.op == aloc_pkg::OP_OR && busy_o)
    else $error("or not decoded");

  AST_BUS8_EXTRA: assert property (@(posedge core_clk_i) disable iff (srst_i)
    take && q.st == S_MODRM && q.opc == 8'hf7 && sub == 3'h6 && mod_mem && bus8_i
    |=> dec_o.cyc_min == 7'h30)
    else $error("narrow bus word memory penalty missing");

  AST_WD_BITS: assert property (@(posedge core_clk_i) disable iff (srst_i)
    take && q.st == S_MODRM && q.opc[7:2] == 6'h08
    |=> dec_o.word == $past(q.opc[0]) && dec_o.dir == $past(q.opc[1]))
    else $error("width or direction bit lost");

endmodule : aloc_decode

/* testbench/test_arith_logic_opcode_decode.sv */
`timescale 1ns/1ps
module test_arith_logic_opcode_decode;
  logic core_clk;
  logic srst;
  logic bus8;
  logic byte_valid;
  logic [7:0] byte_data;
  logic byte_ready;
  aloc_pkg::aloc_dec_s dec;
  logic busy;
  logic done;
  logic illegal;
  int err_count;
  int samples_checked;

  aloc_decode aloc_decode_inst (
    .core_clk_i(core_clk),
    .srst_i(srst),
    .bus8_i(bus8),
    .byte_valid_i(byte_valid),
    .byte_i(byte_data),
    .byte_ready_o(byte_ready),
    .dec_o(dec),
    .busy_o(busy),
    .done_o(done),
    .illegal_o(illegal)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // offer a byte from the current edge and hold it until an edge takes it
  task automatic send(input logic [7:0] b, output int waits);
    waits = 0;
    byte_valid <= 1'b1;
    byte_data <= b;
    @(negedge core_clk);
    while (byte_ready !== 1'b1 && waits < 200)
    begin
      @(negedge core_clk);
      waits++;
    end
    if (waits >= 200)
      check(16'(waits), 16'h0, "byte never taken");
    @(posedge core_clk);
  endtask : send

  task automatic run_op(input logic [7:0] b0, input logic [7:0] b1, input bit two,
                        input logic b8, input aloc_pkg::aloc_op_e op, input logic w,
                        input logic m, input logic [6:0] cmin, input logic [6:0] cmax);
    int waits;
    int nb;
    int kd;
    int nd;
    nb = 0;
    kd = 0;
    nd = 0;
    bus8 <= b8;
    send(b0, waits);
    if (two)
      send(b1, waits);
    byte_valid <= 1'b0;
    @(negedge core_clk);
    check(16'(dec.op), 16'(op), "operation");
    check({15'h0, dec.word}, {15'h0, w}, "word select");
    check({15'h0, dec.mem}, {15'h0, m}, "memory form");
    check(16'(dec.cyc_min), 16'(cmin), "min count");
    check(16'(dec.cyc_max), 16'(cmax), "max count");
    check({15'h0, illegal}, 16'h0, "illegal flag");
    // busy length and done position must match the low count
    while (busy === 1'b1 && nb < 100)
    begin
      nb++;
      if (done === 1'b1)
      begin
        nd++;
        kd = nb;
      end
      if (byte_ready !== 1'b0)
        check({15'h0, byte_ready}, 16'h0, "ready while busy");
      @(negedge core_clk);
    end
    check(16'(nb), 16'(cmin), "busy cycles");
    check(16'(kd), 16'(cmin), "done position");
    check(16'(nd), 16'h1, "done pulses");
    check({15'h0, byte_ready}, 16'h1, "ready after done");
    @(posedge core_clk);
  endtask : run_op

  task automatic run_bad(input logic [7:0] b0, input logic [7:0] b1,
                         input aloc_pkg::aloc_op_e held);
    int waits;
    send(b0, waits);
    send(b1, waits);
    byte_valid <= 1'b0;
    @(negedge core_clk);
    check({15'h0, illegal}, 16'h1, "illegal pulse");
    check({15'h0, busy}, 16'h0, "busy on illegal");
    check(16'(dec.op), 16'(held), "held decode");
    @(negedge core_clk);
    check({15'h0, illegal}, 16'h0, "illegal width");
    @(posedge core_clk);
  endtask : run_bad

  // second byte is refused while the first one is timing
  task automatic run_refuse;
    int waits;
    send(8'h98, waits);
    send(8'h99, waits);
    byte_valid <= 1'b0;
    check(16'(waits), 16'h2, "refused byte waits");
    @(negedge core_clk);
    check(16'(dec.op), 16'(aloc_pkg::OP_SXW), "second decode");
    check(16'(dec.cyc_min), 16'h4, "second count");
    for (int i = 0; i < 10 && busy === 1'b1; i++)
      @(negedge core_clk);
    @(posedge core_clk);
  endtask : run_refuse

  task automatic run_reset_mid;
    int waits;
    send(8'hf7, waits);
    send(8'he9, waits);
    byte_valid <= 1'b0;
    repeat (5) @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    check({14'h0, busy, byte_ready}, 16'h1, "busy and ready in reset");
    check(16'(dec.op), 16'(aloc_pkg::OP_NONE), "decode in reset");
    @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
  endtask : run_reset_mid

  initial
  begin
    err_count = 0;
    samples_checked = 0;
    srst = 1'b1;
    bus8 = 1'b0;
    byte_valid = 1'b0;
    byte_data = 8'h00;
    repeat (19) @(posedge core_clk);
    @(negedge core_clk);
    check({13'h0, byte_ready, busy, done}, 16'h4, "reset outputs");
    check(16'(dec.op), 16'(aloc_pkg::OP_NONE), "reset decode");
    @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    run_op(8'hf6, 8'he8, 1, 0, aloc_pkg::OP_SMUL, 0, 0, 7'd25, 7'd28);
    run_op(8'hf7, 8'he9, 1, 1, aloc_pkg::OP_SMUL, 1, 0, 7'd34, 7'd37);
    run_op(8'hf7, 8'h36, 1, 0, aloc_pkg::OP_UDIV, 1, 1, 7'd44, 7'd44);
    run_op(8'hf7, 8'h36, 1, 1, aloc_pkg::OP_UDIV, 1, 1, 7'd48, 7'd48);
    run_op(8'hf6, 8'hf9, 1, 0, aloc_pkg::OP_SDIV, 0, 0, 7'd44, 7'd52);
    run_op(8'hf7, 8'hfa, 1, 0, aloc_pkg::OP_SDIV, 1, 0, 7'd53, 7'd61);
    run_op(8'hd4, 8'h0a, 1, 0, aloc_pkg::OP_ADJ_MUL, 0, 0, 7'd19, 7'd19);
    run_op(8'hd5, 8'h0a, 1, 0, aloc_pkg::OP_ADJ_DIV, 0, 0, 7'd15, 7'd15);
    run_op(8'h98, 8'h00, 0, 0, aloc_pkg::OP_SXB, 0, 0, 7'd2, 7'd2);
    run_op(8'h99, 8'h00, 0, 0, aloc_pkg::OP_SXW, 1, 0, 7'd4, 7'd4);
    run_op(8'h23, 8'hc1, 1, 0, aloc_pkg::OP_AND, 1, 0, 7'd3, 7'd3);
    check({15'h0, dec.dir}, 16'h1, "direction set");
    check({13'h0, dec.reg_f}, 16'h0, "reg field");
    check({13'h0, dec.rm}, 16'h1, "rm field");
    run_op(8'h20, 8'h06, 1, 1, aloc_pkg::OP_AND, 0, 1, 7'd10, 7'd10);
    check({15'h0, dec.dir}, 16'h0, "direction clear");
    run_op(8'h21, 8'h06, 1, 1, aloc_pkg::OP_AND, 1, 1, 7'd14, 7'd14);
    run_op(8'h85, 8'hc0, 1, 0, aloc_pkg::OP_TEST, 1, 0, 7'd3, 7'd3);
    check({14'h0, dec.imm, dec.acc}, 16'h0, "register form flags");
    run_op(8'ha8, 8'h00, 0, 0, aloc_pkg::OP_TEST, 0, 0, 7'd3, 7'd3);
    run_op(8'ha9, 8'h00, 0, 0, aloc_pkg::OP_TEST, 1, 0, 7'd4, 7'd4);
    check({14'h0, dec.imm, dec.acc}, 16'h3, "accumulator form flags");
    run_op(8'h0a, 8'hc3, 1, 0, aloc_pkg::OP_OR, 0, 0, 7'd3, 7'd3);
    check({15'h0, dec.dir}, 16'h1, "or direction");
    run_op(8'h09, 8'h06, 1, 0, aloc_pkg::OP_OR, 1, 1, 7'd10, 7'd10);
    run_op(8'h0d, 8'h00, 0, 0, aloc_pkg::OP_OR, 1, 0, 7'd4, 7'd4);
    run_bad(8'hd4, 8'h0b, aloc_pkg::OP_OR);
    run_bad(8'hf6, 8'hd0, aloc_pkg::OP_OR);
    run_refuse();
    run_reset_mid();
    run_op(8'hf6, 8'hea, 1, 0, aloc_pkg::OP_SMUL, 0, 0, 7'd25, 7'd28);
    run_op(8'hf6, 8'h2f, 1, 1, aloc_pkg::OP_SMUL, 0, 1, 7'd32, 7'd34);
    run_op(8'hf7, 8'h3e, 1, 0, aloc_pkg::OP_SDIV, 1, 1, 7'd59, 7'd67);
    run_op(8'h81, 8'h26, 1, 1, aloc_pkg::OP_AND, 1, 1, 7'd20, 7'd20);
    check({14'h0, dec.imm, dec.acc}, 16'h2, "immediate form flags");
    check({13'h0, dec.reg_f}, 16'h4, "immediate sub field");
    check({13'h0, dec.rm}, 16'h6, "immediate rm field");
    run_op(8'h80, 8'hc8, 1, 0, aloc_pkg::OP_OR, 0, 0, 7'd4, 7'd4);
    run_op(8'hf6, 8'h06, 1, 0, aloc_pkg::OP_TEST, 0, 1, 7'd10, 7'd10);
    run_op(8'hf7, 8'hc0, 1, 1, aloc_pkg::OP_TEST, 1, 0, 7'd4, 7'd4);
    run_bad(8'h37, 8'hd6, aloc_pkg::OP_TEST);
    end_of_test();
  end

  // the sequence needs under 2000 cycles; give it far more
  initial
  begin
    #100000;
    err_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule : test_arith_logic_opcode_decode
